// ===== rtl/afmt_formatter.sv
// Output stage of a 14-bit sampling converter: format, scramble, dither, buses
//
// Notes on behaviour
// - Format pin: low levels offset, high twos
// - Stabilizer on only at middle format levels
// - Each word 14 bits plus overflow flag
// - Single-ended: per-bus range error flags
// - Differential: one flag high on range error
// - Full rate: output clock is inverted encode clock
// - Bus A changes on true clock fall
// - Demux: bus B changes on true fall
// - Full rate drives bus A only
// - Demux output clocks run half encode rate
// - Scramble XORs LSB into upper bits
// - LSB, flag, clock untouched by scramble
// - Scramble only while enable pin high
// - Dither code drives DAC, subtracted from result
// - Mode pin: full, demux, low-power, standard
`timescale 1ns/1ns
`include "afmt_params.svh"

module afmt_formatter (
  // System clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset_n,
  // Configuration pins
  input  wire logic [1:0]                fmt_pin_level,
  input  wire logic [1:0]                out_mode_pin_level,
  input  wire logic                      scramble_enable,
  input  wire logic                      dither_enable,
  // Status towards buffers and clock path
  output logic                           stabilizer_enable,
  output logic                           lvds_active,
  output logic                           lvds_low_power,
  // Converter core, encode domain
  input  wire logic                      encode_clock,
  input  wire afmt_pkg::afmt_sample_t    conv_sample,
  output logic [`AFMT_DITHER_W-1:0]      dither_dac_code,
  // Output buses
  output logic [`AFMT_DATA_W-1:0]        bus_a_data,
  output logic                           bus_a_range_error,
  output logic [`AFMT_DATA_W-1:0]        bus_b_data,
  output logic                           bus_b_range_error,
  output logic                           range_error_flag,
  output logic                           sample_clock_out_true,
  output logic                           sample_clock_out_comp
);

  // ****************************************
  // Pin synchronisers, system side
  // ****************************************
  logic [`AFMT_PIN_W-1:0]    pins_s;
  afmt_pkg::afmt_sys_state_t sys_reg;
  afmt_pkg::afmt_sys_state_t sys_next;
  logic [1:0]                fmt_lvl_s;
  logic [1:0]                mode_lvl_s;

  afmt_sync #(.W(`AFMT_PIN_W)) u_pin_sync (
    .clk (clk_sys),
    .d   ({fmt_pin_level, out_mode_pin_level, scramble_enable, dither_enable}),
    .q   (pins_s)
  );

  assign fmt_lvl_s  = pins_s[5:4];
  assign mode_lvl_s = pins_s[3:2];

  // Decode the level pins; settings are quasi-static, so a level crossing suffices
  always_comb begin
    sys_next = sys_reg;
    if (!reset_n) begin
      sys_next.cfg = afmt_pkg::afmt_cfg_t'(`AFMT_CFG_RST);
    end else begin
      sys_next.cfg.twos       = (fmt_lvl_s == `AFMT_LVL_TWOTHIRD) ||
                                (fmt_lvl_s == `AFMT_LVL_VDD);
      sys_next.cfg.stabilizer = (fmt_lvl_s == `AFMT_LVL_THIRD) ||
                                (fmt_lvl_s == `AFMT_LVL_TWOTHIRD);
      sys_next.cfg.out_mode   = afmt_pkg::afmt_out_mode_t'(mode_lvl_s);
      sys_next.cfg.scramble   = pins_s[1];
      sys_next.cfg.dither     = pins_s[0];
    end
  end

  // System state register
  always_ff @(posedge clk_sys) begin
    sys_reg <= sys_next;
  end

  // Buffer and clock-path controls
  assign stabilizer_enable = sys_reg.cfg.stabilizer;
  assign lvds_active       = sys_reg.cfg.out_mode[1];
  assign lvds_low_power    = (sys_reg.cfg.out_mode == afmt_pkg::AFMT_MODE_LVDS_LP);

  // ****************************************
  // Crossing into the encode domain
  // ****************************************
  logic                 enc_rst_n;
  logic [5:0]           cfg_bits;
  afmt_pkg::afmt_cfg_t  cfg_enc;
  logic                 demux;
  logic                 plain;

  // Reset is carried over as a level; hold it for several encode periods
  afmt_sync #(.W(1)) u_rst_sync (
    .clk (encode_clock),
    .d   (reset_n),
    .q   (enc_rst_n)
  );

  afmt_sync #(.W(6)) u_cfg_sync (
    .clk (encode_clock),
    .d   (sys_reg.cfg),
    .q   (cfg_bits)
  );

  assign cfg_enc = afmt_pkg::afmt_cfg_t'(cfg_bits);
  assign demux   = (cfg_enc.out_mode == afmt_pkg::AFMT_MODE_DEMUX);
  assign plain   = !cfg_enc.twos && !cfg_enc.scramble;

  // ****************************************
  // Encode-domain datapath
  // ****************************************
  afmt_pkg::afmt_enc_state_t enc_reg;
  afmt_pkg::afmt_enc_state_t enc_next;
  logic [`AFMT_DATA_W:0]     diff;
  afmt_pkg::afmt_sample_t    shaped;

  // Format first, then scramble; flag and LSB pass untouched
  function automatic afmt_pkg::afmt_sample_t afmt_shape(
    input afmt_pkg::afmt_sample_t s,
    input afmt_pkg::afmt_cfg_t    c
  );
    afmt_pkg::afmt_sample_t r;
    r = s;
    if (c.twos) begin
      r.data[`AFMT_MSB] = ~s.data[`AFMT_MSB];
    end
    if (c.scramble) begin
      r.data[`AFMT_MSB:1] = r.data[`AFMT_MSB:1] ^ {`AFMT_MSB{r.data[0]}};
    end
    return r;
  endfunction : afmt_shape

  // Dither removal; a borrow clamps to zero and reports under range
  assign diff   = {1'b0, conv_sample.data} -
                  {{(`AFMT_DATA_W+1-`AFMT_DITHER_W){1'b0}}, enc_reg.dither};
  assign shaped = afmt_shape(enc_reg.word, cfg_enc);

  // Next state of the encode-side pipeline
  always_comb begin
    enc_next = enc_reg;
    if (!enc_rst_n) begin
      enc_next        = '0;
      enc_next.lfsr   = `AFMT_LFSR_SEED;
      enc_next.dither = `AFMT_DITHER_RST;
    end else begin
      // Long-sequence generator steps once per sample while dither is on
      if (cfg_enc.dither) begin
        enc_next.lfsr   = {enc_reg.lfsr[13:0], enc_reg.lfsr[14] ^ enc_reg.lfsr[13]};
        enc_next.dither = enc_reg.lfsr[`AFMT_DITHER_W-1:0];
      end else begin
        enc_next.dither = `AFMT_DITHER_RST;
      end
      // Same code that sat on the DAC for this sample is removed here
      if (diff[`AFMT_DATA_W]) begin
        enc_next.word.data = '0;
        enc_next.word.over = 1'b1;
      end else begin
        enc_next.word.data = diff[`AFMT_DATA_W-1:0];
        enc_next.word.over = conv_sample.over;
      end
      // Bus steering
      if (demux) begin
        enc_next.half = ~enc_reg.half;
        if (!enc_reg.half) begin
          enc_next.hold = shaped;
        end else begin
          enc_next.a = shaped;
          enc_next.b = enc_reg.hold;
        end
      end else begin
        enc_next.half = 1'b0;
        enc_next.a    = shaped;
        enc_next.b    = '0;
      end
    end
  end

  // Encode state register
  always_ff @(posedge encode_clock) begin
    enc_reg <= enc_next;
  end

  // ****************************************
  // Output pins
  // ****************************************
  // Data and flag leave the same flops so they never skew apart
  assign bus_a_data        = enc_reg.a.data;
  assign bus_a_range_error = enc_reg.a.over;
  assign bus_b_data        = enc_reg.b.data;
  assign bus_b_range_error = enc_reg.b.over;
  assign range_error_flag  = cfg_enc.out_mode[1] & enc_reg.a.over;
  assign dither_dac_code   = enc_reg.dither;

  // Full rate: inverted encode so the true clock falls as data moves.
  // Demux: the toggle bit falls with the bus update and rises mid-word.
  assign sample_clock_out_true = demux ? enc_reg.half : ~encode_clock;
  assign sample_clock_out_comp = demux ? ~enc_reg.half : encode_clock;

  // ****************************************
  // Checks, system domain
  // ****************************************
  a_stab_level: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    $past(reset_n) |->
      stabilizer_enable == (($past(fmt_lvl_s) == `AFMT_LVL_THIRD) ||
                            ($past(fmt_lvl_s) == `AFMT_LVL_TWOTHIRD)))
    else $error("stabilizer enable does not follow format level");

  // Format choice follows the upper half of the level code
  a_fmt_level: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    $past(reset_n) |-> sys_reg.cfg.twos == $past(fmt_lvl_s[1]))
    else $error("format choice does not follow format level");

  // ****************************************
  // Checks, encode domain
  // ****************************************
  sequence s_demux_pair;
    (!enc_reg.half && demux && plain) ##1 (enc_reg.half && demux && plain);
  endsequence

  sequence s_diff_two;
    cfg_enc.out_mode[1] ##1 cfg_enc.out_mode[1];
  endsequence

  a_fmt_offset: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    (!demux && plain) |=> bus_a_data == $past(enc_reg.word.data))
    else $error("offset binary word differs from result");

  a_fmt_twos: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    (!demux && cfg_enc.twos && !cfg_enc.scramble) |=>
      (bus_a_data[`AFMT_MSB] == !$past(enc_reg.word.data[`AFMT_MSB])) &&
      (bus_a_data[`AFMT_MSB-1:0] == $past(enc_reg.word.data[`AFMT_MSB-1:0])))
    else $error("twos complement word is not MSB-inverted result");

  a_scram_bits: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    (!demux && cfg_enc.scramble) |=>
      bus_a_data[`AFMT_MSB-1:1] ==
        ($past(enc_reg.word.data[`AFMT_MSB-1:1]) ^ {12{$past(enc_reg.word.data[0])}}))
    else $error("scrambled bits are not XOR with LSB");

  a_scram_lsb: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    !demux |=> (bus_a_data[0] == $past(enc_reg.word.data[0])) &&
               (bus_a_range_error == $past(enc_reg.word.over)))
    else $error("LSB or flag altered on bus A");

  a_demux_clock: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    demux |=> sample_clock_out_true != $past(sample_clock_out_true))
    else $error("demux output clock did not toggle");

  a_demux_pair: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    s_demux_pair |=>
      (bus_b_data == $past(enc_reg.word.data, 2)) &&
      (bus_b_range_error == $past(enc_reg.word.over, 2)) &&
      (bus_a_data == $past(enc_reg.word.data)) &&
      (bus_a_range_error == $past(enc_reg.word.over)))
    else $error("demux buses not paired B then A");

  a_data_hold: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    (demux && $past(demux) && enc_reg.half) |->
      $stable(bus_a_data) && $stable(bus_b_data))
    else $error("demux bus changed while true clock high");

  a_range_diff: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    s_diff_two |-> range_error_flag == $past(enc_reg.word.over))
    else $error("differential range flag mismatch");

  a_dither_sub: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    !diff[`AFMT_DATA_W] |=>
      enc_reg.word.data == `AFMT_DATA_W'($past(conv_sample.data) -
                                         `AFMT_DATA_W'($past(enc_reg.dither))))
    else $error("dither code not subtracted from result");

  a_dither_off: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    !cfg_enc.dither |=> dither_dac_code == `AFMT_DITHER_RST)
    else $error("dither DAC driven while dither off");

  // The DAC code is the generator state of the previous sample
  a_dither_step: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    ($past(enc_rst_n) && $past(cfg_enc.dither)) |->
      dither_dac_code == $past(enc_reg.lfsr[`AFMT_DITHER_W-1:0]))
    else $error("dither DAC code does not follow generator");

  // Outside demux the B bus stays parked at zero
  a_bus_b_idle: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    !demux |=> (bus_b_data == '0) && !bus_b_range_error)
    else $error("bus B active outside demux mode");

  // Single-ended modes keep the differential flag low
  a_diff_cmos: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    !cfg_enc.out_mode[1] |-> !range_error_flag)
    else $error("differential flag raised in single-ended mode");

  // Outside demux the two output clocks are exact complements
  a_clk_pair: assert property (
    @(posedge encode_clock) disable iff (!enc_rst_n)
    !demux |-> sample_clock_out_comp == !sample_clock_out_true)
    else $error("output clocks not complementary");

endmodule : afmt_formatter

// ===== rtl/afmt_params.svh
// Constants of the converter output formatter: widths, level codes, reset values
`ifndef AFMT_PARAMS_SVH
`define AFMT_PARAMS_SVH

// ****************************************
// Widths
// ****************************************
`define AFMT_DATA_W       14
`define AFMT_MSB          13
`define AFMT_LFSR_W       15
`define AFMT_DITHER_W     8
`define AFMT_PIN_W        6

// ****************************************
// Four-level pin codes from the level comparator
// ****************************************
`define AFMT_LVL_GND      2'h0
`define AFMT_LVL_THIRD    2'h1
`define AFMT_LVL_TWOTHIRD 2'h2
`define AFMT_LVL_VDD      2'h3

// ****************************************
// Reset values
// ****************************************
`define AFMT_LFSR_SEED    15'h4A5B
`define AFMT_CFG_RST      6'h00
`define AFMT_DITHER_RST   8'h00

`endif

// ===== rtl/afmt_pkg.sv
// Types shared by the converter output formatter
`include "afmt_params.svh"

package afmt_pkg;

  // ****************************************
  // Output mode, lowest pin level first
  // ****************************************
  typedef enum logic [1:0] {
    AFMT_MODE_FULL    = 2'b00,
    AFMT_MODE_DEMUX   = 2'b01,
    AFMT_MODE_LVDS_LP = 2'b10,
    AFMT_MODE_LVDS    = 2'b11
  } afmt_out_mode_t;

  // ****************************************
  // Carriers and state
  // ****************************************
  typedef struct packed {
    logic [`AFMT_DATA_W-1:0] data;
    logic                    over;
  } afmt_sample_t;

  typedef struct packed {
    afmt_out_mode_t out_mode;
    logic           twos;
    logic           scramble;
    logic           dither;
    logic           stabilizer;
  } afmt_cfg_t;

  typedef struct packed {
    afmt_cfg_t cfg;
  } afmt_sys_state_t;

  typedef struct packed {
    logic [`AFMT_LFSR_W-1:0]   lfsr;
    logic [`AFMT_DITHER_W-1:0] dither;
    afmt_sample_t              word;
    afmt_sample_t              hold;
    afmt_sample_t              a;
    afmt_sample_t              b;
    logic                      half;
  } afmt_enc_state_t;

endpackage : afmt_pkg

// ===== rtl/afmt_sync.sv
// Two-flop level synchroniser, parameterised in width
`timescale 1ns/1ns

module afmt_sync #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Level from the other domain
  input  wire logic [W-1:0] d,
  // Synchronised level
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } afmt_sync_state_t;

  afmt_sync_state_t sync_reg;
  afmt_sync_state_t sync_next;

  // First stage feeds only the second; no reset so a strap is never forced
  always_comb begin
    sync_next        = sync_reg;
    sync_next.meta   = d;
    sync_next.stable = sync_reg.meta;
  end

  // State register
  always_ff @(posedge clk) begin
    sync_reg <= sync_next;
  end

  assign q = sync_reg.stable;

endmodule : afmt_sync

// ===== verif/afmt_capture_model.sv
// Capture model of the logic that receives the converter output buses
`timescale 1ns/1ns
`include "afmt_params.svh"

module afmt_capture_model (
  // Capture clock and buses
  input  wire logic                    sample_clock_out_true,
  input  wire logic [`AFMT_DATA_W-1:0] bus_a_data,
  input  wire logic [`AFMT_DATA_W-1:0] bus_b_data,
  input  wire logic                    bus_b_range_error,
  // Captured and restored words
  output logic      [`AFMT_DATA_W-1:0] cap_a,
  output logic      [`AFMT_DATA_W-1:0] cap_b,
  output logic                         cap_b_flag,
  output logic      [`AFMT_DATA_W-1:0] plain_a,
  output logic      [15:0]             cap_count
);
  initial cap_count = 16'h0000;

  // Latch both buses on the rising true clock, mid-way between updates
  always @(posedge sample_clock_out_true) begin
    cap_a      <= bus_a_data;
    cap_b      <= bus_b_data;
    cap_b_flag <= bus_b_range_error;
    plain_a    <= {bus_a_data[13:1] ^ {13{bus_a_data[0]}}, bus_a_data[0]};
    cap_count  <= cap_count + 16'h0001;
  end
endmodule : afmt_capture_model

// ===== verif/afmt_formatter_tb.sv
// Self-checking bench of the converter output formatter
`timescale 1ns/1ns
`include "afmt_params.svh"

module afmt_formatter_tb;
  logic                 clk_sys, reset_n, encode_clock;
  logic [1:0]           fmt_pin_level, out_mode_pin_level;
  logic                 scramble_enable, dither_enable;
  afmt_pkg::afmt_sample_t conv_sample;
  logic                 stabilizer_enable, lvds_active, lvds_low_power;
  logic [7:0]           dither_dac_code;
  logic [13:0]          bus_a_data, bus_b_data, cap_a, cap_b, plain_a;
  logic                 bus_a_range_error, bus_b_range_error, range_error_flag, cap_b_flag;
  logic                 sample_clock_out_true, sample_clock_out_comp;
  logic [15:0]          cap_count;
  int                   err_total, cmp_count, cyc;

  afmt_formatter afmt_formatter_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .fmt_pin_level(fmt_pin_level), .out_mode_pin_level(out_mode_pin_level),
    .scramble_enable(scramble_enable), .dither_enable(dither_enable),
    .stabilizer_enable(stabilizer_enable), .lvds_active(lvds_active),
    .lvds_low_power(lvds_low_power), .encode_clock(encode_clock),
    .conv_sample(conv_sample), .dither_dac_code(dither_dac_code),
    .bus_a_data(bus_a_data), .bus_a_range_error(bus_a_range_error),
    .bus_b_data(bus_b_data), .bus_b_range_error(bus_b_range_error),
    .range_error_flag(range_error_flag), .sample_clock_out_true(sample_clock_out_true),
    .sample_clock_out_comp(sample_clock_out_comp));

  afmt_capture_model afmt_capture_model_inst (.sample_clock_out_true(sample_clock_out_true),
    .bus_a_data(bus_a_data), .bus_b_data(bus_b_data), .bus_b_range_error(bus_b_range_error),
    .cap_a(cap_a), .cap_b(cap_b), .cap_b_flag(cap_b_flag), .plain_a(plain_a),
    .cap_count(cap_count));

  // ****************************************
  // Clocks; the encode clock is offset so no edge lines up with clk_sys
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    encode_clock = 1'b0;
    #17;
    forever begin
      #62 encode_clock = 1'b1;
      #63 encode_clock = 1'b0;
    end
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report();
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // Pins first, then the sample; ten encode periods cover both sync paths
  task automatic apply(input logic [1:0] fmt, input logic [1:0] mode, input logic scr,
                       input logic dit, input afmt_pkg::afmt_sample_t smp);
    @(negedge clk_sys);
    fmt_pin_level      = fmt;
    out_mode_pin_level = mode;
    scramble_enable    = scr;
    dither_enable      = dit;
    @(negedge encode_clock);
    conv_sample = smp;
    repeat (10) @(negedge encode_clock);
  endtask : apply

  // Every format and mode level decoded on the status outputs
  task automatic test_pin_decode();
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_sys);
      fmt_pin_level      = i[1:0];
      out_mode_pin_level = i[3:2];
      repeat (5) @(negedge clk_sys);
      check("stabilizer", {15'h0, i[1:0] == 2'h1 || i[1:0] == 2'h2}, {15'h0, stabilizer_enable});
      check("lvds_active", {15'h0, i[3]}, {15'h0, lvds_active});
      check("lvds_low_power", {15'h0, i[3:2] == 2'h2}, {15'h0, lvds_low_power});
    end
  endtask : test_pin_decode

  // Format, scramble and flags across full-rate and both differential modes
  task automatic test_format();
    logic [1:0]  mode;
    logic [13:0] d;
    logic        ovr;
    logic [15:0] n0;
    for (int i = 0; i < 8; i++) begin
      mode = (i % 3 == 0) ? 2'h0 : ((i % 3 == 1) ? 2'h2 : 2'h3);
      d    = 14'h1235 + 14'(2 * i);
      ovr  = i[0] ^ i[2];
      apply(i[1:0], mode, i[2], 1'b0, '{data: d, over: ovr});
      #10;
      d = i[1] ? (d ^ 14'h2000) : d;
      n0 = cap_count;
      repeat (2) @(negedge encode_clock);
      #10;
      check("plain_a", {2'h0, i[2] ? d : {d[13:1] ^ {13{d[0]}}, d[0]}}, {2'h0, plain_a});
      check("captures", n0 + 16'h0002, cap_count);
      d = i[2] ? {d[13:1] ^ {13{d[0]}}, d[0]} : d;
      check("bus_a_data", {2'h0, d}, {2'h0, bus_a_data});
      check("bus_a_flag", {15'h0, ovr}, {15'h0, bus_a_range_error});
      check("flag", {15'h0, ovr & mode[1]}, {15'h0, range_error_flag});
      check("bus_b_data", 16'h0000, {2'h0, bus_b_data});
      check("clock_true", 16'h0001, {15'h0, sample_clock_out_true});
      check("clock_comp", 16'h0000, {15'h0, sample_clock_out_comp});
    end
  endtask : test_format

  // Counting samples on the demux buses; older sample must sit on B
  task automatic test_demux();
    logic [15:0] n0;
    apply(2'h0, 2'h1, 1'b0, 1'b0, '{data: 14'h0100, over: 1'b0});
    n0 = cap_count;
    for (int k = 1; k <= 32; k++) begin
      @(negedge encode_clock);
      conv_sample = '{data: 14'h0100 + 14'(k), over: k[0]};
    end
    check("demux_rate", n0 + 16'h0010, cap_count);
    check("demux_pair", {2'h0, cap_b + 14'h0001}, {2'h0, cap_a});
    check("demux_flag_b", {15'h0, cap_b[0]}, {15'h0, cap_b_flag});
  endtask : test_demux

  // Dither code must be taken back out of the result
  task automatic test_dither();
    logic [7:0] h [4];
    int         hits, moves;
    hits  = 0;
    moves = 0;
    apply(2'h0, 2'h0, 1'b0, 1'b1, '{data: 14'h2000, over: 1'b0});
    for (int k = 0; k < 16; k++) begin
      @(negedge encode_clock);
      h[3] = h[2];
      h[2] = h[1];
      h[1] = h[0];
      h[0] = dither_dac_code;
      if (h[0] !== h[1]) moves++;
      for (int j = 0; j < 4; j++) if (bus_a_data === 14'h2000 - {6'h0, h[j]}) hits++;
    end
    check("dither_moves", 16'h0001, {15'h0, moves > 8});
    check("dither_match", 16'h0001, {15'h0, hits >= 12});
    apply(2'h0, 2'h0, 1'b0, 1'b0, '{data: 14'h2000, over: 1'b0});
    check("dither_off", 16'h0000, {8'h0, dither_dac_code});
    check("plain_out", 16'h2000, {2'h0, bus_a_data});
  endtask : test_dither

  // Reset is held past six encode periods so the encode side sees it
  initial begin
    reset_n            = 1'b0;
    fmt_pin_level      = 2'h0;
    out_mode_pin_level = 2'h0;
    scramble_enable    = 1'b0;
    dither_enable      = 1'b0;
    conv_sample        = '{data: 14'h0000, over: 1'b0};
    err_total          = 0;
    cmp_count          = 0;
    cyc                = 0;
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (10) @(negedge encode_clock);
    test_pin_decode();
    test_format();
    test_demux();
    test_dither();
    final_report();
  end
endmodule : afmt_formatter_tb
